// [rtl/aum_pkg.sv]
// Package for the uncorrectable error mask and severity register bank
package aum_pkg;

   // Byte offsets on the register bus
   localparam logic [9:0] OFS_STATUS = 10'h104;
   localparam logic [9:0] OFS_MASK = 10'h108;
   localparam logic [9:0] OFS_SEVERITY = 10'h10C;
   localparam logic [9:0] OFS_MEM_CTL = 10'h140;
   localparam logic [9:0] OFS_IRQ_STATUS = 10'h180;
   localparam logic [9:0] OFS_IRQ_MASK = 10'h184;
   localparam logic [9:0] OFS_FIRST_ERR = 10'h188;

   // Bit positions
   localparam int BIT_LEGACY = 0;
   localparam int BIT_LINK_PROTO = 4;
   localparam int BIT_SURPRISE_DOWN = 5;
   localparam int BIT_POISONED = 12;
   localparam int BIT_FLOW_CTRL = 13;
   localparam int BIT_COMPL_TIMEOUT = 14;
   localparam int BIT_COMPL_ABORT = 15;
   localparam int BIT_UNEXP_COMPL = 16;
   localparam int BIT_RCV_OVERFLOW = 17;
   localparam int BIT_MALFORMED = 18;
   localparam int BIT_ECRC = 19;
   localparam int BIT_UNSUP_REQ = 20;
   localparam int BIT_ACS_VIOL = 21;
   localparam int BIT_DOUBLE_BIT = 31;
   localparam int BIT_DBE_REPORT_EN = 0;

   // Writable bits of each register
   localparam logic [31:0] MASK_WR_BITS = 32'h803F_3031;
   localparam logic [31:0] SEV_WR_BITS = 32'h803F_3031;

   // Reset values
   localparam logic [31:0] MASK_RST = 32'h0000_0000;
   localparam logic [31:0] SEV_RST = 32'h0006_2030;
   localparam logic [31:0] MEM_CTL_RST = 32'h0000_0000;
   localparam logic [4:0] FIRST_ERR_RST = 5'h00;

   // Interrupt status bits
   localparam int IRQ_FATAL = 0;
   localparam int IRQ_NONFATAL = 1;
   localparam int IRQ_W = 2;

   typedef enum logic [1:0] {
      AUM_IDLE = 2'b00,
      AUM_ANSWER = 2'b01
   } aum_bus_e;

   typedef struct packed {
      logic fatal;
      logic nonfatal;
   } aum_report_s;

endpackage

// [rtl/aum_regs.sv]
// Uncorrectable error mask and severity register bank with reporting
`timescale 1ns/1ns
// Notes on behaviour
// (RL1) Masked malformed, ECRC, UR, ACS events: logged in status, no pointer update, no report.
// (RL2) Mask bits never affect the status register bits.
// (RL3) Double bit mask works only when the double bit report enable is set.
// (RL4) Double bit mask reads zero and ignores writes while report enable clear.
// (RL5) Unmasked event reports fatal if severity set, else non-fatal.
// (RL6) Severity read-write bits sit at 0, 4, 5, 12, 13, 16 to 21, and 31 while report enable set.
// (RL7) Severity bits 4, 5, 13, 17, 18 reset to one; 12, 16 to zero.
// (RL8) Completion timeout severity bit 14 is read-only zero.
// (RL9) Completer abort severity bit 15 is read-only zero.
// (RL10) Severity bit 0 is plain storage with no effect.
// (RL11) Sticky fields survive hot reset; power-on reset restores all defaults, hot reset restores only the first error pointer.
// (RL12) Reserved bits read zero and ignore writes.
module aum_regs (
   // Clock and resets
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic hot_rst_i,
   // Avalon-MM slave
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Error events from the port, one-cycle pulses
   input wire logic [31:0] err_event_i,
   // Reporting toward the root complex
   output logic report_fatal_o,
   output logic report_nonfatal_o,
   output logic [4:0] first_error_pointer_o,
   output logic irq_o
);

   localparam int IRQ_W_L = aum_pkg::IRQ_W;

   // Register state
   logic [31:0] status_q;
   logic [31:0] mask_q;
   logic [31:0] severity_q;
   logic [31:0] mem_ctl_q;
   logic [IRQ_W_L-1:0] irq_status_q;
   logic [IRQ_W_L-1:0] irq_mask_q;
   logic [4:0] first_err_q;
   logic first_valid_q;
   logic [31:0] readdata_q;
   aum_pkg::aum_bus_e bus_q;
   aum_pkg::aum_report_s report_q;
   logic irq_q;

   logic dbe_en;
   logic [31:0] wmask;
   logic [31:0] wdata;
   logic wr_go;
   logic [31:0] eff_mask;
   logic [31:0] evt;
   logic [31:0] unmasked;
   logic [31:0] mask_view;
   logic [31:0] sev_view;
   logic [31:0] st_clr;
   logic [4:0] first_idx;
   aum_pkg::aum_report_s report_d;
   logic found;
   logic wait_d;
   logic [31:0] first_view;
   logic [31:0] irq_st_view;
   logic [31:0] irq_msk_view;
   logic [31:0] mask_we;
   logic [31:0] sev_we;

   // Decoded write strobes, valid only in the answer cycle
   logic sel_status;
   logic sel_mask;
   logic sel_sev;
   logic sel_mem;
   logic sel_irq_st;
   logic sel_irq_msk;
   logic rd_go;
   logic rearm;
   logic [IRQ_W_L-1:0] irq_set;
   logic [IRQ_W_L-1:0] irq_clr;
   logic [IRQ_W_L-1:0] irq_pend;
   logic [31:0] readdata_d;

   assign sel_status = wr_go && (avs_address_i == aum_pkg::OFS_STATUS);
   assign sel_mask = wr_go && (avs_address_i == aum_pkg::OFS_MASK);
   assign sel_sev = wr_go && (avs_address_i == aum_pkg::OFS_SEVERITY);
   assign sel_mem = wr_go && (avs_address_i == aum_pkg::OFS_MEM_CTL);
   assign sel_irq_st = wr_go && (avs_address_i == aum_pkg::OFS_IRQ_STATUS);
   assign sel_irq_msk = wr_go && (avs_address_i == aum_pkg::OFS_IRQ_MASK);
   assign rd_go = avs_read_i && (bus_q == aum_pkg::AUM_IDLE);

   assign dbe_en = mem_ctl_q[aum_pkg::BIT_DBE_REPORT_EN];
   assign wr_go = avs_write_i && (bus_q == aum_pkg::AUM_ANSWER);
   assign wdata = avs_writedata_i;
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{avs_byteenable_i[b]}};
      end
   end

   // Double bit mask only counts when reporting is enabled
   always_comb begin
      eff_mask = mask_q;
      eff_mask[aum_pkg::BIT_DOUBLE_BIT] = mask_q[aum_pkg::BIT_DOUBLE_BIT] && dbe_en; // see (RL3)
   end

   // Double bit events only exist while reporting is enabled
   always_comb begin
      evt = err_event_i & aum_pkg::MASK_WR_BITS;
      evt[aum_pkg::BIT_LEGACY] = 1'b0; // see (RL10)
      evt[aum_pkg::BIT_DOUBLE_BIT] = err_event_i[aum_pkg::BIT_DOUBLE_BIT] && dbe_en;
   end

   assign unmasked = evt & ~eff_mask; // see (RL1)

   // Views as software reads them
   always_comb begin
      mask_view = mask_q & aum_pkg::MASK_WR_BITS; // see (RL12)
      if (!dbe_en) begin
         mask_view[aum_pkg::BIT_DOUBLE_BIT] = 1'b0; // see (RL4)
      end
   end

   // Stored bit 31 is kept, only hidden while reporting is off
   always_comb begin
      sev_view = severity_q & aum_pkg::SEV_WR_BITS; // see (RL6) (RL8) (RL9)
      if (!dbe_en) begin
         sev_view[aum_pkg::BIT_DOUBLE_BIT] = 1'b0;
      end
   end

   assign irq_st_view = {{(32-IRQ_W_L){1'b0}}, irq_status_q};
   assign irq_msk_view = {{(32-IRQ_W_L){1'b0}}, irq_mask_q};
   assign first_view = {26'h0, first_valid_q, first_err_q};

   // Per-bit write enables; bit 31 stays shut while reporting is off
   always_comb begin
      mask_we = wmask & aum_pkg::MASK_WR_BITS; // see (RL12)
      sev_we = wmask & aum_pkg::SEV_WR_BITS; // see (RL8) (RL9) (RL10)
      if (!dbe_en) begin
         mask_we[aum_pkg::BIT_DOUBLE_BIT] = 1'b0; // see (RL4)
         sev_we[aum_pkg::BIT_DOUBLE_BIT] = 1'b0;
      end
   end

   // Lowest unmasked event sets the first error pointer
   always_comb begin
      first_idx = 5'h00;
      found = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (unmasked[i] && !found) begin
            first_idx = 5'(i);
            found = 1'b1;
         end
      end
   end

   // Severity decides the message class
   always_comb begin
      report_d.fatal = |(unmasked & severity_q); // see (RL5)
      report_d.nonfatal = |(unmasked & ~severity_q); // see (RL5)
   end

   // Bus handshake: one wait cycle, then answer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         bus_q <= aum_pkg::AUM_IDLE;
      end else begin
         case (bus_q)
            aum_pkg::AUM_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_q <= aum_pkg::AUM_ANSWER;
               end
            end
            aum_pkg::AUM_ANSWER: bus_q <= aum_pkg::AUM_IDLE;
            default: bus_q <= aum_pkg::AUM_IDLE;
         endcase
      end
   end

   always_comb begin
      wait_d = 1'b1;
      if ((avs_read_i || avs_write_i) && bus_q == aum_pkg::AUM_IDLE) begin
         wait_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         avs_waitrequest_o <= 1'b1;
      end else begin
         avs_waitrequest_o <= wait_d;
      end
   end

   // Read mux; unmapped reads return zero
   always_comb begin
      readdata_d = 32'h0000_0000;
      case (avs_address_i)
         aum_pkg::OFS_STATUS: readdata_d = status_q;
         aum_pkg::OFS_MASK: readdata_d = mask_view;
         aum_pkg::OFS_SEVERITY: readdata_d = sev_view;
         aum_pkg::OFS_MEM_CTL: readdata_d = mem_ctl_q & 32'h0000_0001;
         aum_pkg::OFS_IRQ_STATUS: readdata_d = irq_st_view;
         aum_pkg::OFS_IRQ_MASK: readdata_d = irq_msk_view;
         aum_pkg::OFS_FIRST_ERR: readdata_d = first_view;
         default: readdata_d = 32'h0000_0000;
      endcase
   end

   // Captured on the taken edge so it stands when waitrequest drops
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         readdata_q <= 32'h0000_0000;
      end else if (rd_go) begin
         readdata_q <= readdata_d;
      end
   end
   assign avs_readdata_o = readdata_q;

   // Sticky mask; hot reset deliberately not looked at
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mask_q <= aum_pkg::MASK_RST; // see (RL11)
      end else if (sel_mask) begin
         for (int i = 0; i < 32; i++) begin
            if (mask_we[i]) begin // see (RL4) (RL12)
               mask_q[i] <= wdata[i];
            end
         end
      end
   end

   // Sticky severity
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         severity_q <= aum_pkg::SEV_RST; // see (RL7) (RL11)
      end else if (sel_sev) begin
         for (int i = 0; i < 32; i++) begin
            if (sev_we[i]) begin // see (RL8) (RL9) (RL10)
               severity_q[i] <= wdata[i];
            end
         end
      end
   end

   // Memory error control: report enable for double bit errors
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_ctl_q <= aum_pkg::MEM_CTL_RST;
      end else if (sel_mem && avs_byteenable_i[0]) begin
         mem_ctl_q <= {31'h0, wdata[aum_pkg::BIT_DBE_REPORT_EN]};
      end
   end

   // One sticky cell per status bit; masks never reach here, set beats clear
   for (genvar g = 0; g < 32; g++) begin : g_status
      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            status_q[g] <= 1'b0;
         end else if (evt[g]) begin
            status_q[g] <= 1'b1; // see (RL2)
         end else if (st_clr[g]) begin
            status_q[g] <= 1'b0;
         end
      end
   end
   assign st_clr = sel_status ? (wdata & wmask) : 32'h0;

   // Pointer re-arms once software clears the status bit it points at
   assign rearm = first_valid_q && st_clr[first_err_q];

   // First error pointer; frozen until status of that bit is cleared
   always_ff @(posedge clk_i) begin
      if (srst_i || hot_rst_i) begin
         first_err_q <= aum_pkg::FIRST_ERR_RST;
         first_valid_q <= 1'b0;
      end else if (|unmasked && (!first_valid_q || rearm)) begin
         first_err_q <= first_idx; // see (RL1)
         first_valid_q <= 1'b1;
      end else if (rearm) begin
         first_valid_q <= 1'b0;
      end
   end

   // Message pulses to the root complex
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         report_q.fatal <= 1'b0;
      end else begin
         report_q.fatal <= report_d.fatal; // see (RL1) (RL5)
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         report_q.nonfatal <= 1'b0;
      end else begin
         report_q.nonfatal <= report_d.nonfatal; // see (RL1) (RL5)
      end
   end

   // Interrupt causes; set wins over a write-one-clear in the same cycle
   always_comb begin
      irq_set = '0;
      irq_set[aum_pkg::IRQ_FATAL] = report_d.fatal;
      irq_set[aum_pkg::IRQ_NONFATAL] = report_d.nonfatal;
      irq_clr = '0;
      if (sel_irq_st && avs_byteenable_i[0]) begin
         irq_clr = wdata[IRQ_W_L-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_mask_q <= '0;
      end else if (sel_irq_msk && avs_byteenable_i[0]) begin
         irq_mask_q <= wdata[IRQ_W_L-1:0];
      end
   end

   assign irq_pend = irq_status_q & irq_mask_q;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |irq_pend;
      end
   end

   assign report_fatal_o = report_q.fatal;
   assign report_nonfatal_o = report_q.nonfatal;
   assign first_error_pointer_o = first_err_q;
   assign irq_o = irq_q;

endmodule

// [testbench/aum_regs_props.sv]
// Port assertions for the mask and severity bank
`timescale 1ns/1ns
module aum_regs_props (
   // Clock and resets
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic hot_rst_i,
   // Register bus
   input wire logic [9:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   // Events and reports
   input wire logic [31:0] err_event_i,
   input wire logic report_fatal_o,
   input wire logic report_nonfatal_o,
   input wire logic [4:0] first_error_pointer_o
);
   localparam logic [31:0] WR = aum_pkg::SEV_WR_BITS;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic rep;
   logic done;
   assign rep = report_fatal_o || report_nonfatal_o;
   assign done = avs_read_i && !avs_waitrequest_o;
   property p_cause; rep |-> $past(err_event_i) != 32'h0; endproperty
   a_cause: assert property (p_cause) else $error("report without event");
   property p_legacy; err_event_i == 32'h1 |=> !rep; endproperty
   a_legacy: assert property (p_legacy) else $error("legacy bit reported");
   // Events on read-only or reserved places never report
   property p_resv; err_event_i != 32'h0 && (err_event_i & WR) == 32'h0 |=> !rep; endproperty
   a_resv: assert property (p_resv) else $error("reserved event reported");
   property p_hot; hot_rst_i && err_event_i == 32'h0 |=> first_error_pointer_o == 5'h00; endproperty
   a_hot: assert property (p_hot) else $error("pointer kept over hot reset");
   property p_sev; done && avs_address_i == aum_pkg::OFS_SEVERITY |-> (avs_readdata_o & ~WR) == 32'h0;
   endproperty
   a_sev: assert property (p_sev) else $error("severity fixed bits not zero");
   property p_msk; done && avs_address_i == aum_pkg::OFS_MASK |-> (avs_readdata_o & ~WR) == 32'h0;
   endproperty
   a_msk: assert property (p_msk) else $error("mask reserved bits not zero");
   property p_unmap; done && avs_address_i == 10'h000 |-> avs_readdata_o == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_ans; avs_read_i && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o; endproperty
   a_ans: assert property (p_ans) else $error("read not answered");
endmodule
bind aum_regs aum_regs_props u_props (.clk_i, .srst_i, .hot_rst_i, .avs_address_i, .avs_read_i,
   .avs_readdata_o, .avs_waitrequest_o, .err_event_i, .report_fatal_o, .report_nonfatal_o,
   .first_error_pointer_o);

// [testbench/aum_rc_model.sv]
// Root complex stand-in counting error messages
`timescale 1ns/1ns
module aum_rc_model (
   // Clock and reset
   input wire logic clk_i,
   input wire logic srst_i,
   // Messages
   input wire logic fatal_i,
   input wire logic nonfatal_i,
   output logic [7:0] fatal_n_o,
   output logic [7:0] nonfatal_n_o
);
   // Each pulse is one message, so a stuck report counts every cycle
   always_ff @(posedge clk_i) begin
      fatal_n_o <= srst_i ? 8'h00 : fatal_n_o + {7'h00, fatal_i};
      nonfatal_n_o <= srst_i ? 8'h00 : nonfatal_n_o + {7'h00, nonfatal_i};
   end
endmodule

// [testbench/aum_regs_tb_top.sv]
// Testbench for the mask and severity register bank
`timescale 1ns/1ns
module aum_regs_tb_top;
   localparam logic [9:0] SEV = aum_pkg::OFS_SEVERITY;
   localparam logic [9:0] MSK = aum_pkg::OFS_MASK;
   localparam logic [9:0] STA = aum_pkg::OFS_STATUS;
   logic clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic hot_rst_i = 1'b0;
   logic [9:0] avs_address_i = 10'h000;
   logic avs_read_i = 1'b0;
   logic avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hF;
   logic [31:0] avs_readdata_o;
   logic avs_waitrequest_o;
   logic [31:0] err_event_i = 32'h0;
   logic report_fatal_o;
   logic report_nonfatal_o;
   logic [4:0] first_error_pointer_o;
   logic irq_o;
   logic [7:0] fat_n;
   logic [7:0] nf_n;
   logic [31:0] q;
   logic [4:0] p;
   int bad_count = 0;
   int n_checks = 0;
   always #20 clk_i = ~clk_i;
   aum_regs dut (.clk_i, .srst_i, .hot_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
      .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .err_event_i,
      .report_fatal_o, .report_nonfatal_o, .first_error_pointer_o, .irq_o);
   aum_rc_model rc (.clk_i, .srst_i, .fatal_i(report_fatal_o), .nonfatal_i(report_nonfatal_o),
      .fatal_n_o(fat_n), .nonfatal_n_o(nf_n));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Request held until the edge that samples waitrequest low
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic w = 1'b1);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= !w;
      avs_writedata_i <= d;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e, input string n);
      wr(a, 32'h0, 1'b0);
      chk(n, e, q);
   endtask
   task automatic ev(input logic [31:0] b, input logic [7:0] ef, input logic [7:0] en);
      logic [7:0] f0;
      logic [7:0] n0;
      f0 = fat_n;
      n0 = nf_n;
      @(posedge clk_i);
      err_event_i <= b;
      @(posedge clk_i);
      err_event_i <= 32'h0;
      repeat (3) @(posedge clk_i);
      chk("fatal", 32'(f0 + ef), 32'(fat_n));
      chk("nonfatal", 32'(n0 + en), 32'(nf_n));
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_i);
      bad_count++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(SEV, aum_pkg::SEV_RST, "sev_rst");
      rd(10'h000, 32'h0, "unmapped");
      wr(SEV, 32'hFFFF_FFFF);
      rd(SEV, 32'h003F_3031, "sev_rw");
      wr(MSK, 32'hFFFF_FFFF);
      rd(MSK, 32'h003F_3031, "mask_rw");
      wr(MSK, 32'h0);
      wr(SEV, 32'h0004_0000);
      ev(32'h0004_0000, 1, 0);
      ev(32'h0000_1000, 0, 1);
      ev(32'h0000_0001, 0, 0);
      ev(32'h0000_C000, 0, 0);
      $display("Test severity done");
      wr(STA, 32'hFFFF_FFFF);
      wr(MSK, 32'h003C_0000);
      p = first_error_pointer_o;
      for (int i = 18; i < 22; i++) ev(32'h1 << i, 0, 0);
      chk("pointer", {27'h0, p}, {27'h0, first_error_pointer_o});
      rd(STA, 32'h003C_0000, "status");
      wr(STA, 32'hFFFF_FFFF);
      wr(MSK, 32'h0);
      ev(32'h0008_0000, 0, 1);
      ev(32'h8000_0000, 0, 0);
      wr(aum_pkg::OFS_MEM_CTL, 32'h1);
      wr(MSK, 32'h8000_0000);
      rd(MSK, 32'h8000_0000, "dbe_mask");
      ev(32'h8000_0000, 0, 0);
      wr(STA, 32'hFFFF_FFFF);
      wr(MSK, 32'h0);
      ev(32'h8000_0000, 0, 1);
      wr(MSK, 32'h8000_0000);
      wr(aum_pkg::OFS_MEM_CTL, 32'h0);
      rd(MSK, 32'h0, "dbe_off");
      $display("Test mask done");
      wr(aum_pkg::OFS_IRQ_STATUS, 32'h3);
      wr(aum_pkg::OFS_IRQ_MASK, 32'h2);
      wr(STA, 32'hFFFF_FFFF);
      ev(32'h0004_0000, 1, 0);
      chk("irq_masked", 32'h0, {31'h0, irq_o});
      ev(32'h0000_1000, 0, 1);
      chk("irq_set", 32'h1, {31'h0, irq_o});
      wr(aum_pkg::OFS_IRQ_STATUS, 32'h2);
      repeat (2) @(posedge clk_i);
      chk("irq_clr", 32'h0, {31'h0, irq_o});
      $display("Test interrupt done");
      hot_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      hot_rst_i <= 1'b0;
      rd(SEV, 32'h0004_0000, "sev_hot");
      srst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      srst_i <= 1'b0;
      rd(SEV, aum_pkg::SEV_RST, "sev_por");
      $display("Test reset done");
      complete_run();
   end
endmodule
